//--- rtl/scw_top.sv
// Channel word register, feedback divider and lock detector
`timescale 1ns/1ps
`default_nettype none
module scw_top #(
    parameter int LOCK_N = int'(scw_pkg::LOCK_COUNT)
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       ser_clk_in,
    input  wire logic       ser_data_in,
    input  wire logic       ser_latch_in,
    input  wire logic       sleep_pin_in,
    input  wire logic       ref_clk_in,
    input  wire logic       presc_in,
    input  wire logic       pump_up_in,
    input  wire logic       pump_dn_in,
    output logic            enabled_out,
    output logic [1:0]      cp_current_out,
    output logic            cp_off_out,
    output logic            pd_polarity_out,
    output logic            mod_ctrl_out,
    output logic            div_pulse_out,
    output logic            lock_indicator_out
);
    // ============================================================
    // Pin synchronisers
    logic [7:0] pins_s;
    // Pump pins are synchronised one by one and combined afterwards, so no gate sits before a flop
    scw_sync #(.WIDTH(8)) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .async_in   ({ser_clk_in, ser_data_in, ser_latch_in, sleep_pin_in,
                      ref_clk_in, presc_in, pump_up_in, pump_dn_in}),
        .sync_out   (pins_s)
    );
    wire logic sclk_s  = pins_s[7];
    wire logic sdat_s  = pins_s[6];
    wire logic slat_s  = pins_s[5];
    wire logic sleep_s = pins_s[4];
    wire logic ref_s   = pins_s[3];
    wire logic pre_s   = pins_s[2];
    wire logic pulse_s = pins_s[1] | pins_s[0];

    // ============================================================
    // State
    logic [7:0]                   prev;
    logic [scw_pkg::FRAME_W-1:0]  shreg, main_word, ref_word;
    logic                         en_eff, locked, bad_seen;
    logic [scw_pkg::MAIN_W-1:0]   main_cnt;
    logic [scw_pkg::SWAL_W-1:0]   swal_cnt;
    logic [3:0]                   good_cnt;
    logic [scw_pkg::PER_W-1:0]    ref_cnt, ref_per, wid_cnt;
    logic [scw_pkg::FRAME_W-1:0]  next_shreg, next_main_word, next_ref_word;
    logic                         next_en_eff, next_locked, next_bad_seen;
    logic [scw_pkg::MAIN_W-1:0]   next_main_cnt;
    logic [scw_pkg::SWAL_W-1:0]   next_swal_cnt;
    logic [3:0]                   next_good_cnt;
    logic [scw_pkg::PER_W-1:0]    next_ref_cnt, next_ref_per, next_wid_cnt;
    logic                         next_enabled, next_mod, next_div, next_ld;
    logic [1:0]                   next_cur;

    wire logic sclk_rise = sclk_s & ~prev[7];
    wire logic lat_rise  = slat_s & ~prev[5];
    wire logic ref_rise  = ref_s & ~prev[3];
    wire logic pre_rise  = pre_s & ~prev[2];
    // Frame seen by the latch edge includes the bits shifted so far
    wire logic take      = lat_rise & ~sclk_s;
    wire logic frame_ok  = take & ~shreg[scw_pkg::BIT_CSEL];
    wire logic wr_chan   = frame_ok & ~shreg[scw_pkg::BIT_RSEL];
    wire logic wr_ref    = frame_ok & shreg[scw_pkg::BIT_RSEL];
    wire logic forced    = ref_word[scw_pkg::REF_RELOAD];
    wire logic running   = enabled_out;
    wire logic per_end   = running & pre_rise & (main_cnt <= 11'h001);
    wire logic long_det  = pulse_s & (wid_cnt > ref_per) & (ref_per != 12'h000);

    function automatic logic [scw_pkg::MAIN_W-1:0] main_ratio(
        input logic [scw_pkg::FRAME_W-1:0] w);
        main_ratio = w[scw_pkg::MAIN_LSB +: scw_pkg::MAIN_W];
    endfunction

    function automatic logic [scw_pkg::SWAL_W-1:0] swal_ratio(
        input logic [scw_pkg::FRAME_W-1:0] w);
        swal_ratio = w[scw_pkg::SWAL_LSB +: scw_pkg::SWAL_W];
    endfunction

    // ============================================================
    // Next-state logic
    always_comb begin
        next_shreg     = shreg;
        next_main_word = main_word;
        next_ref_word  = ref_word;
        next_en_eff    = en_eff;
        // Bits 24 down to 1 arrive in order; bit 1 ends in index 0
        if (sclk_rise) begin
            next_shreg = {shreg[scw_pkg::FRAME_W-2:0], sdat_s};
        end
        // Registers change only on a write, and a write is taken in powerdown too
        if (wr_chan) begin
            // Bits 20 and 21 are stored but nothing reads them
            next_main_word = shreg;
            next_en_eff    = shreg[scw_pkg::CH_EN_BIT];
        end else if (wr_ref) begin
            next_ref_word  = shreg;
            next_en_eff    = shreg[scw_pkg::REF_EN_BIT];
            // Self-clearing reset bit drops both enables
            if (shreg[scw_pkg::REF_RESET]) begin
                next_ref_word[scw_pkg::REF_RESET]  = 1'b0;
                next_ref_word[scw_pkg::REF_EN_BIT] = 1'b0;
                next_main_word[scw_pkg::CH_EN_BIT] = 1'b0;
                next_en_eff                        = 1'b0;
            end
        end
        next_enabled = sleep_s & en_eff;
        next_cur = main_word[scw_pkg::BAND_BIT] ?
                   ref_word[scw_pkg::REF_B2_LSB +: scw_pkg::CUR_W] :
                   ref_word[scw_pkg::REF_B1_LSB +: scw_pkg::CUR_W];

        // Feedback divider: halted in powerdown, counts held except when a forced-reload channel write loads them
        next_main_cnt = main_cnt;
        next_swal_cnt = swal_cnt;
        next_div      = 1'b0;
        if (running && pre_rise) begin
            if (main_cnt <= 11'h001) begin
                next_main_cnt = main_ratio(main_word);
                next_swal_cnt = swal_ratio(main_word);
                next_div      = 1'b1;
            end else begin
                next_main_cnt = main_cnt - 11'h001;
                if (swal_cnt != 7'h00) begin
                    next_swal_cnt = swal_cnt - 7'h01;
                end
            end
        end
        if (wr_chan && forced) begin
            next_main_cnt = main_ratio(shreg);
            next_swal_cnt = swal_ratio(shreg);
        end
        // 65 while swallow count remains, else 64
        next_mod = (next_swal_cnt != 7'h00);

        // Reference period measured in system clocks
        next_ref_cnt = ref_rise ? 12'h001 :
                       (&ref_cnt ? ref_cnt : ref_cnt + 12'h001);
        next_ref_per = ref_rise ? ref_cnt : ref_per;
        next_wid_cnt = pulse_s ? (&wid_cnt ? wid_cnt : wid_cnt + 12'h001) : 12'h000;

        next_locked   = locked;
        next_good_cnt = good_cnt;
        next_bad_seen = bad_seen;
        if (long_det) begin
            next_locked   = 1'b0;
            next_good_cnt = 4'h0;
            next_bad_seen = 1'b1;
        end else if (per_end) begin
            next_bad_seen = 1'b0;
            if (bad_seen) begin
                next_good_cnt = 4'h0;
            end else if (good_cnt < 4'(LOCK_N)) begin
                next_good_cnt = good_cnt + 4'h1;
                if (good_cnt == 4'(LOCK_N - 1)) begin
                    next_locked = 1'b1;
                end
            end
        end
        next_ld = ref_word[scw_pkg::REF_LDEN] ? next_locked : 1'b1;
    end

    // ============================================================
    // Registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev               <= 8'h00;
            shreg              <= scw_pkg::WORD_RST;
            main_word          <= scw_pkg::WORD_RST;
            ref_word           <= scw_pkg::WORD_RST;
            en_eff             <= 1'b0;
            locked             <= 1'b0;
            bad_seen           <= 1'b0;
            main_cnt           <= 11'h000;
            swal_cnt           <= 7'h00;
            good_cnt           <= 4'h0;
            ref_cnt            <= 12'h000;
            ref_per            <= 12'h000;
            wid_cnt            <= 12'h000;
            enabled_out        <= 1'b0;
            cp_current_out     <= 2'h0;
            cp_off_out         <= 1'b0;
            pd_polarity_out    <= 1'b0;
            mod_ctrl_out       <= 1'b0;
            div_pulse_out      <= 1'b0;
            lock_indicator_out <= 1'b1;
        end else if (ce_in) begin
            prev               <= pins_s;
            shreg              <= next_shreg;
            main_word          <= next_main_word;
            ref_word           <= next_ref_word;
            en_eff             <= next_en_eff;
            locked             <= next_locked;
            bad_seen           <= next_bad_seen;
            main_cnt           <= next_main_cnt;
            swal_cnt           <= next_swal_cnt;
            good_cnt           <= next_good_cnt;
            ref_cnt            <= next_ref_cnt;
            ref_per            <= next_ref_per;
            wid_cnt            <= next_wid_cnt;
            enabled_out        <= next_enabled;
            cp_current_out     <= next_cur;
            cp_off_out         <= ref_word[scw_pkg::REF_CPOFF];
            pd_polarity_out    <= ref_word[scw_pkg::REF_POL];
            mod_ctrl_out       <= next_mod;
            div_pulse_out      <= next_div;
            lock_indicator_out <= next_ld;
        end
    end

    // ============================================================
    // Assertions
    property p_chan_write;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && wr_chan) |=> (main_word == $past(shreg))
                               && (en_eff == $past(shreg[scw_pkg::CH_EN_BIT]));
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel write lost");

    property p_band;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && main_word[scw_pkg::BAND_BIT]) |=>
            cp_current_out == $past(ref_word[scw_pkg::REF_B2_LSB +: scw_pkg::CUR_W]);
    endproperty
    a_band: assert property (p_band) else $error("band two current wrong");

    property p_enable;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in |=> enabled_out == $past(sleep_s && en_eff);
    endproperty
    a_enable: assert property (p_enable) else $error("enable mismatch");

    property p_ref_en;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && wr_ref && !shreg[scw_pkg::REF_RESET]) |=>
            en_eff == $past(shreg[scw_pkg::REF_EN_BIT]);
    endproperty
    a_ref_en: assert property (p_ref_en) else $error("reference enable ignored");

    property p_retain;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && !frame_ok) |=> $stable(main_word) && $stable(ref_word);
    endproperty
    a_retain: assert property (p_retain) else $error("register changed");

    property p_lock_rise;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(locked) |-> $past(per_end) && $past(good_cnt) == 4'(LOCK_N - 1);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("early lock");

    property p_long;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && long_det) |=> !locked && good_cnt == 4'h0 ##1 !locked;
    endproperty
    a_long: assert property (p_long) else $error("long pulse kept lock");

    property p_cs_ignore;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && take && shreg[scw_pkg::BIT_CSEL]) |=> $stable(main_word) && $stable(en_eff);
    endproperty
    a_cs_ignore: assert property (p_cs_ignore) else $error("deselected frame taken");

    property p_forced;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && wr_chan && forced) |=> main_cnt == $past(main_ratio(shreg));
    endproperty
    a_forced: assert property (p_forced) else $error("forced reload missed");

    property p_ld_off;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && !ref_word[scw_pkg::REF_LDEN]) |=> lock_indicator_out;
    endproperty
    a_ld_off: assert property (p_ld_off) else $error("lock output low while disabled");

    c_lock:   cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(locked));
    c_chan:   cover property (@(posedge sys_clk_in) disable iff (rst_in) wr_chan);
    c_csign:  cover property (@(posedge sys_clk_in) disable iff (rst_in)
                              take && shreg[scw_pkg::BIT_CSEL]);
    c_unlock: cover property (@(posedge sys_clk_in) disable iff (rst_in) locked && long_det);
endmodule
`default_nettype wire

//--- rtl/scw_pkg.sv
// Constants for the synthesizer channel word and lock detect block
// Functional notes
// - Channel bit 22 enables, zero powers down
// - Channel bit 23 picks current band
// - Channel bits 20 and 21 ignored
// - Bits 2..8 unsigned 7-bit swallow count
// - Bits 9..19 unsigned 11-bit main ratio
// - Main counter divides prescaler output by ratio
// - Enabled only with sleep pin high, enable
// - Latest written register's enable bit governs
// - Register contents kept during powerdown
// - Band bit selects programmed current setting
// - Lock after 15 consecutive short-pulse periods
// - Any long pulse drops lock, restarts count
// - 24-bit frame, MSB first, latch rise
// - Chip select one ignores; select bit routes
// - Synchronous reload at count one, forced on latch
// - Lock output high while detect disabled
package scw_pkg;
    // ============================================================
    // Frame layout (index = printed bit number minus one)
    localparam int FRAME_W     = 24;
    localparam int BIT_RSEL    = 0;
    localparam int SWAL_LSB    = 1;
    localparam int SWAL_W      = 7;
    localparam int MAIN_LSB    = 8;
    localparam int MAIN_W      = 11;
    localparam int CH_EN_BIT   = 21;
    localparam int BAND_BIT    = 22;
    localparam int BIT_CSEL    = 23;
    // ============================================================
    // Reference word fields
    localparam int REF_RELOAD  = 12;
    localparam int REF_CPOFF   = 13;
    localparam int REF_B2_LSB  = 14;
    localparam int REF_POL     = 16;
    localparam int REF_B1_LSB  = 17;
    localparam int REF_RESET   = 19;
    localparam int REF_EN_BIT  = 21;
    localparam int REF_LDEN    = 22;
    localparam int CUR_W       = 2;
    // ============================================================
    // Reset values and counts
    localparam logic [23:0] WORD_RST   = 24'h00_0000;
    localparam logic [3:0]  LOCK_COUNT = 4'hF;
    localparam int          PER_W      = 12;
endpackage

//--- rtl/scw_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module scw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage    <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            stage    <= async_in;
            sync_out <= stage;
        end
    end
endmodule
`default_nettype wire

//--- test/scw_host.sv
// Host controller model driving the three-wire programming bus
`timescale 1ns/1ps
`default_nettype none
module scw_host (
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic ser_latch_out
);
    // ============================================================
    // Idle bus: clock stands low between frames
    initial begin
        ser_clk_out   = 1'b0;
        ser_data_out  = 1'b0;
        ser_latch_out = 1'b0;
    end
    // ============================================================
    // One frame: chip select first, register select last
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data_out = w[i];
            #12;
            ser_clk_out = 1'b1;
            #24;
            ser_clk_out = 1'b0;
            #12;
        end
        #12;
        ser_latch_out = 1'b1;
        #48;
        ser_latch_out = 1'b0;
        // Hold time over: show the inverse so no stale bit looks valid
        ser_data_out = ~w[0];
    endtask
endmodule
`default_nettype wire

//--- test/scw_top_tb_top.sv
// Self-checking bench for the channel word and lock detect block
`timescale 1ns/1ps
`default_nettype none
module scw_top_tb_top;
    // ============================================================
    // Pins, generators and counters
    localparam int LOCK_N = 3;
    localparam int PP     = 6;
    logic       sys_clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       sleep_pin_in = 1'b1;
    logic       ref_clk_in = 1'b0;
    logic       presc_in = 1'b0;
    logic       pump_up_in = 1'b0;
    logic       pump_dn_in = 1'b0;
    logic       ser_clk, ser_data, ser_latch;
    logic       enabled_out, cp_off_out, pd_polarity_out;
    logic       mod_ctrl_out, div_pulse_out, lock_indicator_out;
    logic [1:0] cp_current_out;
    logic       presc_run = 1'b0;
    int         ph = 0, rph = 0, rises = 0, mod_hi = 0, cyc = 0;
    int         miscompares = 0, samples_checked = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    scw_host host (.ser_clk_out(ser_clk), .ser_data_out(ser_data), .ser_latch_out(ser_latch));
    scw_top #(.LOCK_N(LOCK_N)) DUT (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(1'b1), .ser_clk_in(ser_clk),
        .ser_data_in(ser_data), .ser_latch_in(ser_latch), .sleep_pin_in(sleep_pin_in),
        .ref_clk_in(ref_clk_in), .presc_in(presc_in), .pump_up_in(pump_up_in),
        .pump_dn_in(pump_dn_in), .enabled_out(enabled_out), .cp_current_out(cp_current_out),
        .cp_off_out(cp_off_out), .pd_polarity_out(pd_polarity_out),
        .mod_ctrl_out(mod_ctrl_out), .div_pulse_out(div_pulse_out),
        .lock_indicator_out(lock_indicator_out));
    // Reference runs at 20 cycles; prescaler at PP cycles while enabled by the bench
    always @(posedge sys_clk_in) begin
        rph <= (rph == 19) ? 0 : rph + 1;
        ref_clk_in <= (rph < 10);
        if (presc_run) begin
            ph <= (ph == PP - 1) ? 0 : ph + 1;
            presc_in <= (ph < PP / 2);
            if (ph == 0) rises <= rises + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            finish_test();
        end
    end
    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic take(input logic [23:0] w);
        @(posedge sys_clk_in);
        #1;
        host.send(w);
        repeat (8) @(posedge sys_clk_in);
        #1;
    endtask
    // Waits for a divider wrap, counting cycles of divide-by-65 on the way
    task automatic wait_div();
        mod_hi = 0;
        for (int i = 0; i < 400; i++) begin
            // Window runs from just after one wrap up to and including the next: one full period
            @(negedge sys_clk_in);
            if (mod_ctrl_out === 1'b1) mod_hi++;
            if (div_pulse_out === 1'b1) return;
        end
        check(0, 1);
    endtask
    function automatic logic [23:0] chw(input logic b, input logic e, input logic [1:0] x,
                                        input logic [10:0] m, input logic [6:0] a);
        return {1'b0, b, e, x, m, a, 1'b0};
    endfunction
    function automatic logic [23:0] refw(input logic ld, input logic e);
        return {1'b0, ld, e, 2'b00, 2'b01, 1'b0, 2'b10, 2'b00, 11'h002, 1'b1};
    endfunction
    // ============================================================
    // Scenarios
    task automatic t_lock();
        int n;
        take(refw(1'b1, 1'b1));
        take(chw(1'b0, 1'b1, 2'b00, 11'h003, 7'h01));
        check(lock_indicator_out, 0);
        check(enabled_out, 1);
        check(cp_current_out, 2'b01);
        presc_run = 1'b1;
        pump_up_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #1 pump_up_in = 1'b0;
        n = 0;
        while (lock_indicator_out !== 1'b1 && n < 40) begin
            wait_div();
            n++;
            #1;
        end
        check(n, LOCK_N);
        @(posedge sys_clk_in);
        #1 pump_dn_in = 1'b1;
        n = 0;
        while (lock_indicator_out !== 1'b0 && n < 80) begin
            @(posedge sys_clk_in);
            n++;
            #1;
        end
        check(lock_indicator_out, 0);
        repeat (20) @(posedge sys_clk_in);
        #1 pump_dn_in = 1'b0;
        for (n = 0; n < 40 && lock_indicator_out !== 1'b1; n++) begin
            wait_div();
            #1;
        end
        check(n >= LOCK_N && lock_indicator_out === 1'b1, 1);
    endtask
    task automatic t_div();
        int r0;
        take(chw(1'b1, 1'b1, 2'b11, 11'h005, 7'h02));
        check(cp_current_out, 2'b10);
        check(enabled_out, 1);
        wait_div();
        wait_div();
        r0 = rises;
        wait_div();
        check(rises - r0, 5);
        check(mod_hi, 2 * PP);
    endtask
    task automatic t_enable();
        take(chw(1'b1, 1'b0, 2'b00, 11'h005, 7'h02));
        check(enabled_out, 0);
        take(refw(1'b1, 1'b1));
        check(enabled_out, 1);
        take(chw(1'b1, 1'b0, 2'b00, 11'h005, 7'h02) | 24'h80_0000);
        check(enabled_out, 1);
        sleep_pin_in = 1'b0;
        repeat (6) @(posedge sys_clk_in);
        #1;
        check(enabled_out, 0);
        sleep_pin_in = 1'b1;
        repeat (6) @(posedge sys_clk_in);
        #1;
        check({enabled_out, cp_current_out}, 3'b110);
    endtask
    // Forced reload: a long ratio is cut short by a new word at once, not at its wrap
    task automatic t_forced();
        int r0;
        take(refw(1'b1, 1'b1) | 24'h01_3000);
        check({cp_off_out, pd_polarity_out}, 2'b11);
        take(chw(1'b0, 1'b1, 2'b00, 11'h0C8, 7'h00));
        take(chw(1'b0, 1'b1, 2'b00, 11'h004, 7'h01));
        check(cp_current_out, 2'b01);
        wait_div();
        r0 = rises;
        wait_div();
        check(rises - r0, 4);
        take(refw(1'b1, 1'b1) | 24'h08_0000);
        check(enabled_out, 0);
    endtask
    // ============================================================
    // Verdict
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_in);
        #1 rst_in = 1'b0;
        check({enabled_out, lock_indicator_out, div_pulse_out}, 3'b010);
        t_lock();
        t_div();
        t_enable();
        t_forced();
        finish_test();
    end
endmodule
`default_nettype wire
